// [logic/i2c_mon_pkg.sv]
// Constants, types and records of the I2C trigger and frame decoder
// Functional notes
// - SDA fall with SCL high starts frame
// - SDA rise with SCL high ends frame
// - Start before stop fires restart trigger
// - First seven bits address, eighth bit direction
// - Then data bytes, each with acknowledge bit
// - High ninth bit flags and triggers NACK
// - Direction trigger uses eighth bit, selected sense
// - Address reported with or without direction bit
// - Ten-bit addresses up to 1023 supported
// - Address trigger needs address and direction match
// - Optional data pattern up to three bytes
// - Byte offset 0 to 4095 after address
// - Pattern length one to three bytes
// - Per-bit one, zero or don't-care condition
// - Hex entry masks whole bytes only
// - Record holds direction, address, count, data
// - Record start time relative to trigger
// - Record state code with four values
// - Lines sampled at one eighth rate
package i2c_mon_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TADDR = 8'h04;
  localparam logic [7:0] OFS_PVAL = 8'h08;
  localparam logic [7:0] OFS_PCARE = 8'h0C;
  localparam logic [7:0] OFS_PCFG = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_RINFO = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1C;
  localparam logic [7:0] OFS_RTIME = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int C_EN = 0;
  localparam int C_SRST = 1;
  localparam int C_SHORT = 2;
  localparam int C_HEX = 3;
  localparam int C_PATEN = 4;
  localparam int C_DIR = 5;
  localparam int C_MODE = 8;
  localparam int P_OFF = 0;
  localparam int P_LEN = 16;
  localparam int S_TRIG = 0;
  localparam int S_NACK = 1;
  localparam int S_BUSY = 2;
  localparam int S_REC = 3;
  localparam int R_STATE = 0;
  localparam int R_DIR = 2;
  localparam int R_ADDR = 4;
  localparam int R_CNT = 16;

  // ----------------------------------------
  // Timing and protocol constants
  // ----------------------------------------
  localparam logic [2:0] DIV_LAST = 3'h7;
  localparam logic [4:0] TEN_TAG = 5'h1E;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] LEN_MIN = 2'h1;
  localparam logic [12:0] IDX_MAX = 13'h1FFF;

  typedef enum logic [2:0] {
    T_START = 3'h0, T_STOP = 3'h1, T_RESTART = 3'h2, T_NACK = 3'h3,
    T_DIR = 3'h4, T_ADDR = 3'h5, T_NONE = 3'h7
  } trig_mode_t;

  typedef enum logic [1:0] {
    FS_OK = 2'h0, FS_DATA = 2'h1, FS_ADDR_ERR = 2'h2, FS_CUT = 2'h3
  } frame_state_t;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1, PH_ADDR = 4'h2, PH_ADDR2 = 4'h4, PH_DATA = 4'h8
  } phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    frame_state_t state;
    logic dir;
    logic [9:0] addr;
    logic [15:0] count;
    logic [31:0] data;
    logic [31:0] start_time;
  } frame_rec_t;

endpackage

// [logic/i2c_bus_trigger_decoder.sv]
// Passive I2C frame decoder and trigger unit with APB registers
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_trigger_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire i2c_mon_pkg::apb_req_t apb_req,
  output i2c_mon_pkg::apb_rsp_t apb_rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic trig_out,
  output logic frame_done,
  output i2c_mon_pkg::frame_rec_t frame_rec
);

  // ----------------------------------------
  // State of the whole block
  // ----------------------------------------
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic [2:0] div;
    logic fresh;
    logic scl_smp;
    logic sda_smp;
    logic scl_prev;
    logic sda_prev;
    logic en;
    logic srst;
    logic short_fmt;
    logic hex;
    logic pat_en;
    logic dir_sel;
    i2c_mon_pkg::trig_mode_t mode;
    logic [9:0] taddr;
    logic [23:0] pval;
    logic [23:0] pcare;
    logic [11:0] poff;
    logic [1:0] plen;
    logic trig_seen;
    logic nack_seen;
    logic rec_valid;
    i2c_mon_pkg::phase_t ph;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic in_frame;
    logic addr_done;
    logic addr_ok;
    logic dir;
    logic pat_ok;
    logic [9:0] addr;
    logic [12:0] bidx;
    logic [15:0] cnt;
    logic [31:0] data;
    logic [31:0] fr_start;
    logic [31:0] tstamp;
    logic [31:0] trig_time;
    logic [31:0] rec_abs;
    i2c_mon_pkg::frame_rec_t rec;
    logic rec_stb;
    logic trig;
    logic [31:0] prdata;
    logic pslverr;
  } st_t;

  st_t s;
  st_t n;
  logic run;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Compare one byte against value under its care mask
  function automatic logic byte_hit(input logic [7:0] b, input logic [7:0] v,
                                    input logic [7:0] c, input logic hex);
    logic [7:0] m;
    m = hex ? {8{|c}} : c;
    return ((b ^ v) & m) == 8'h00;
  endfunction

  // State code of a frame closed by stop or restart
  function automatic i2c_mon_pkg::frame_state_t frame_code(input st_t st);
    if (st.addr_done) begin
      return i2c_mon_pkg::FS_OK;
    end else if (st.ph == i2c_mon_pkg::PH_ADDR && st.bitcnt <= 4'h1) begin
      // The SCL rise ahead of a stop or restart counts as one stray bit
      return i2c_mon_pkg::FS_DATA;
    end
    return i2c_mon_pkg::FS_ADDR_ERR;
  endfunction

  // Mapped register offsets
  function automatic logic mapped(input logic [7:0] a);
    return a inside {i2c_mon_pkg::OFS_CTRL, i2c_mon_pkg::OFS_TADDR,
                     i2c_mon_pkg::OFS_PVAL, i2c_mon_pkg::OFS_PCARE,
                     i2c_mon_pkg::OFS_PCFG, i2c_mon_pkg::OFS_STAT,
                     i2c_mon_pkg::OFS_RINFO, i2c_mon_pkg::OFS_RDATA,
                     i2c_mon_pkg::OFS_RTIME};
  endfunction

  // Read multiplexer, unmapped reads give zero
  function automatic logic [31:0] reg_read(input st_t st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      i2c_mon_pkg::OFS_CTRL: begin
        r[i2c_mon_pkg::C_EN] = st.en;
        r[i2c_mon_pkg::C_SRST] = st.srst;
        r[i2c_mon_pkg::C_SHORT] = st.short_fmt;
        r[i2c_mon_pkg::C_HEX] = st.hex;
        r[i2c_mon_pkg::C_PATEN] = st.pat_en;
        r[i2c_mon_pkg::C_DIR] = st.dir_sel;
        r[i2c_mon_pkg::C_MODE +: 3] = st.mode;
      end
      i2c_mon_pkg::OFS_TADDR: r[9:0] = st.taddr;
      i2c_mon_pkg::OFS_PVAL: r[23:0] = st.pval;
      i2c_mon_pkg::OFS_PCARE: r[23:0] = st.pcare;
      i2c_mon_pkg::OFS_PCFG: begin
        r[i2c_mon_pkg::P_OFF +: 12] = st.poff;
        r[i2c_mon_pkg::P_LEN +: 2] = st.plen;
      end
      i2c_mon_pkg::OFS_STAT: begin
        r[i2c_mon_pkg::S_TRIG] = st.trig_seen;
        r[i2c_mon_pkg::S_NACK] = st.nack_seen;
        r[i2c_mon_pkg::S_BUSY] = st.in_frame;
        r[i2c_mon_pkg::S_REC] = st.rec_valid;
      end
      i2c_mon_pkg::OFS_RINFO: begin
        r[i2c_mon_pkg::R_STATE +: 2] = st.rec.state;
        r[i2c_mon_pkg::R_DIR] = st.rec.dir;
        r[i2c_mon_pkg::R_ADDR +: 10] = st.rec.addr;
        r[i2c_mon_pkg::R_CNT +: 16] = st.rec.count;
      end
      i2c_mon_pkg::OFS_RDATA: r = st.rec.data;
      i2c_mon_pkg::OFS_RTIME: r = st.rec_abs - st.trig_time;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Line events
  // ----------------------------------------
  // Events are valid only in the cycle after a fresh sample
  assign run = s.en & ~s.srst;
  assign start_ev = s.fresh & s.scl_smp & s.scl_prev & s.sda_prev & ~s.sda_smp;
  assign stop_ev = s.fresh & s.scl_smp & s.scl_prev & ~s.sda_prev & s.sda_smp;
  assign rise_ev = s.fresh & ~s.scl_prev & s.scl_smp;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic fire;
    logic close;
    i2c_mon_pkg::frame_state_t cst;
    logic [7:0] b;
    logic [9:0] a;
    logic [12:0] k;
    logic hit;
    fire = 1'b0;
    close = 1'b0;
    cst = i2c_mon_pkg::FS_OK;
    b = 8'h00;
    a = 10'h000;
    k = 13'h0000;
    hit = 1'b0;
    n = s;
    n.trig = 1'b0;
    n.rec_stb = 1'b0;
    n.tstamp = s.tstamp + 32'h0000_0001;

    n.scl_s1 = scl_in;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = sda_in;
    n.sda_s2 = s.sda_s1;

    n.div = s.div + 3'h1;
    n.fresh = (s.div == i2c_mon_pkg::DIV_LAST);
    if (s.div == i2c_mon_pkg::DIV_LAST) begin
      n.scl_prev = s.scl_smp;
      n.sda_prev = s.sda_smp;
      n.scl_smp = s.scl_s2;
      n.sda_smp = s.sda_s2;
    end

    // APB: read data latched in setup, writes at access
    if (apb_req.psel && !apb_req.penable) begin
      n.prdata = reg_read(s, apb_req.paddr);
      n.pslverr = ~mapped(apb_req.paddr);
    end
    if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
      case (apb_req.paddr)
        i2c_mon_pkg::OFS_CTRL: begin
          n.en = apb_req.pwdata[i2c_mon_pkg::C_EN];
          n.srst = apb_req.pwdata[i2c_mon_pkg::C_SRST];
          n.short_fmt = apb_req.pwdata[i2c_mon_pkg::C_SHORT];
          n.hex = apb_req.pwdata[i2c_mon_pkg::C_HEX];
          n.pat_en = apb_req.pwdata[i2c_mon_pkg::C_PATEN];
          n.dir_sel = apb_req.pwdata[i2c_mon_pkg::C_DIR];
          n.mode = i2c_mon_pkg::trig_mode_t'(apb_req.pwdata[i2c_mon_pkg::C_MODE +: 3]);
        end
        i2c_mon_pkg::OFS_TADDR: n.taddr = apb_req.pwdata[9:0];
        i2c_mon_pkg::OFS_PVAL: n.pval = apb_req.pwdata[23:0];
        i2c_mon_pkg::OFS_PCARE: n.pcare = apb_req.pwdata[23:0];
        i2c_mon_pkg::OFS_PCFG: begin
          n.poff = apb_req.pwdata[i2c_mon_pkg::P_OFF +: 12];
          n.plen = apb_req.pwdata[i2c_mon_pkg::P_LEN +: 2];
          if (n.plen == 2'h0) begin
            n.plen = i2c_mon_pkg::LEN_MIN;
          end
        end
        i2c_mon_pkg::OFS_STAT: begin
          // Write one to clear; later sets override
          n.trig_seen = s.trig_seen & ~apb_req.pwdata[i2c_mon_pkg::S_TRIG];
          n.nack_seen = s.nack_seen & ~apb_req.pwdata[i2c_mon_pkg::S_NACK];
          n.rec_valid = s.rec_valid & ~apb_req.pwdata[i2c_mon_pkg::S_REC];
        end
        default: n.en = s.en;
      endcase
    end

    // Decoder; soft reset outranks everything
    if (s.srst) begin
      n.ph = i2c_mon_pkg::PH_IDLE;
      n.in_frame = 1'b0;
      n.bitcnt = 4'h0;
      n.sh = 8'h00;
      n.addr_done = 1'b0;
      n.addr_ok = 1'b0;
      n.bidx = 13'h0000;
      n.cnt = 16'h0000;
    end else if (!s.en) begin
      if (s.in_frame) begin
        close = 1'b1;
        cst = i2c_mon_pkg::FS_CUT;
      end
      n.in_frame = 1'b0;
      n.ph = i2c_mon_pkg::PH_IDLE;
    end else if (start_ev) begin
      if (s.in_frame) begin
        close = 1'b1;
        cst = frame_code(s);
        fire = (s.mode == i2c_mon_pkg::T_RESTART);
      end
      if (s.mode == i2c_mon_pkg::T_START) begin
        fire = 1'b1;
      end
      n.in_frame = 1'b1;
      n.ph = i2c_mon_pkg::PH_ADDR;
      n.bitcnt = 4'h0;
      n.addr_done = 1'b0;
      n.addr_ok = 1'b0;
      n.addr = 10'h000;
      n.dir = 1'b0;
      n.bidx = 13'h0000;
      n.pat_ok = 1'b1;
      n.cnt = 16'h0000;
      n.data = 32'h0000_0000;
      n.fr_start = s.tstamp;
    end else if (stop_ev) begin
      fire = (s.mode == i2c_mon_pkg::T_STOP);
      if (s.in_frame) begin
        close = 1'b1;
        cst = frame_code(s);
      end
      n.in_frame = 1'b0;
      n.ph = i2c_mon_pkg::PH_IDLE;
    end else if (rise_ev && s.in_frame) begin
      if (s.bitcnt == i2c_mon_pkg::ACK_BIT) begin
        n.bitcnt = 4'h0;
        if (s.sda_smp) begin
          n.nack_seen = 1'b1;
          fire = (s.mode == i2c_mon_pkg::T_NACK);
        end
      end else begin
        b = {s.sh[6:0], s.sda_smp};
        n.sh = b;
        n.bitcnt = s.bitcnt + 4'h1;
        if (s.bitcnt == i2c_mon_pkg::LAST_BIT) begin
          case (s.ph)
            i2c_mon_pkg::PH_ADDR: begin
              n.dir = b[0];
              fire = (s.mode == i2c_mon_pkg::T_DIR) && (b[0] == s.dir_sel);
              if (b[7:3] == i2c_mon_pkg::TEN_TAG && !b[0]) begin
                n.addr = {b[2:1], 8'h00};
                n.ph = i2c_mon_pkg::PH_ADDR2;
              end else begin
                a = s.short_fmt ? {2'b00, b} : {3'b000, b[7:1]};
                n.addr = a;
                n.addr_done = 1'b1;
                n.addr_ok = (a == s.taddr) && (b[0] == s.dir_sel);
                if (s.mode == i2c_mon_pkg::T_ADDR && !s.pat_en && n.addr_ok) begin
                  fire = 1'b1;
                end
                n.ph = i2c_mon_pkg::PH_DATA;
              end
            end
            i2c_mon_pkg::PH_ADDR2: begin
              a = {s.addr[9:8], b};
              n.addr = a;
              n.addr_done = 1'b1;
              n.addr_ok = (a == s.taddr) && (s.dir == s.dir_sel);
              if (s.mode == i2c_mon_pkg::T_ADDR && !s.pat_en && n.addr_ok) begin
                fire = 1'b1;
              end
              n.ph = i2c_mon_pkg::PH_DATA;
            end
            i2c_mon_pkg::PH_DATA: begin
              // data bytes until stop or restart
              n.cnt = s.cnt + 16'h0001;
              n.data = {s.data[23:0], b};
              if (s.bidx != i2c_mon_pkg::IDX_MAX) begin
                n.bidx = s.bidx + 13'h0001;
              end
              k = s.bidx - {1'b0, s.poff};
              if (s.bidx >= {1'b0, s.poff} && k < {11'h000, s.plen}) begin
                hit = s.pat_ok & byte_hit(b, s.pval[{k[1:0], 3'b000} +: 8],
                                          s.pcare[{k[1:0], 3'b000} +: 8], s.hex);
                n.pat_ok = hit;
                if (k == {11'h000, s.plen} - 13'h0001 && hit && s.addr_ok &&
                    s.pat_en && s.mode == i2c_mon_pkg::T_ADDR) begin
                  fire = 1'b1;
                end
              end
            end
            default: n.ph = i2c_mon_pkg::PH_IDLE;
          endcase
        end
      end
    end

    if (close) begin
      n.rec_stb = 1'b1;
      n.rec_valid = 1'b1;
      n.rec.state = cst;
      n.rec.dir = s.dir;
      n.rec.addr = s.addr;
      n.rec.count = s.cnt;
      n.rec.data = s.data;
      n.rec.start_time = s.fr_start - s.trig_time;
      n.rec_abs = s.fr_start;
    end

    // Trigger instant is the time origin
    if (fire) begin
      n.trig = 1'b1;
      n.trig_seen = 1'b1;
      n.trig_time = s.tstamp;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Lines reset high so no false start at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.scl_smp <= 1'b1;
      s.sda_smp <= 1'b1;
      s.scl_prev <= 1'b1;
      s.sda_prev <= 1'b1;
      s.ph <= i2c_mon_pkg::PH_IDLE;
      s.mode <= i2c_mon_pkg::T_START;
      s.plen <= i2c_mon_pkg::LEN_MIN;
      s.pat_ok <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Zero-wait slave; data and error from flops
  assign apb_rsp = '{prdata: s.prdata, pready: 1'b1, pslverr: s.pslverr};
  assign trig_out = s.trig;
  assign frame_done = s.rec_stb;
  assign frame_rec = s.rec;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_start_trig: assert property (start_ev && run && s.mode == i2c_mon_pkg::T_START
    |=> trig_out) else $error("start trigger missing");
  a_stop_trig: assert property (stop_ev && run && s.mode == i2c_mon_pkg::T_STOP
    |=> trig_out && !s.in_frame) else $error("stop trigger missing");
  a_restart_trig: assert property (start_ev && run && s.in_frame &&
    s.mode == i2c_mon_pkg::T_RESTART |=> trig_out && frame_done)
    else $error("restart trigger missing");
  a_dir_capture: assert property (rise_ev && run && s.in_frame &&
    s.ph == i2c_mon_pkg::PH_ADDR && s.bitcnt == i2c_mon_pkg::LAST_BIT
    |=> s.dir == $past(s.sda_smp)) else $error("direction bit wrong");
  a_nack_flag: assert property (rise_ev && run && s.in_frame &&
    s.bitcnt == i2c_mon_pkg::ACK_BIT && s.sda_smp |=> s.nack_seen)
    else $error("nack not flagged");
  a_addr_match: assert property (trig_out && s.mode == i2c_mon_pkg::T_ADDR
    |-> s.addr_ok) else $error("address trigger without match");
  a_sample_rate: assert property (s.fresh |=> !s.fresh [*7] ##1 s.fresh)
    else $error("sample rate not one in eight");
  a_rec_time: assert property (frame_done |-> frame_rec.start_time ==
    $past(s.fr_start) - $past(s.trig_time)) else $error("record time wrong");
  a_cut_state: assert property (s.in_frame && !s.en && !s.srst
    |=> frame_done && frame_rec.state == i2c_mon_pkg::FS_CUT)
    else $error("cut frame not recorded");
  a_soft_clear: assert property (s.srst |=> !s.in_frame &&
    s.ph == i2c_mon_pkg::PH_IDLE) else $error("soft reset ignored");
  a_len_range: assert property (s.plen != 2'h0)
    else $error("pattern length zero");

  c_frame_ok: cover property (frame_done && frame_rec.state == i2c_mon_pkg::FS_OK);
  c_nack: cover property (run && rise_ev && s.bitcnt == i2c_mon_pkg::ACK_BIT && s.sda_smp);
  c_addr_trig: cover property (trig_out && s.mode == i2c_mon_pkg::T_ADDR && s.pat_en);
  c_ten_bit: cover property (s.ph == i2c_mon_pkg::PH_ADDR2);

endmodule
`default_nettype wire

// [verification/i2c_bus_model.sv]
// Behavioural I2C master and addressed slave driving both observed lines
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
  output logic scl,
  output logic sda
);
  // Quarter bit; a 256 ns bit keeps several samples in each SCL half
  localparam int Q = 64;

  // Both lines rest at the pull-up level between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic start();
    sda = 1'b1;
    #Q scl = 1'b1;
    #Q sda = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda = 1'b0;
    #Q scl = 1'b1;
    #Q sda = 1'b1;
    #Q;
  endtask

  task automatic put_byte(input logic [7:0] b, input logic nack);
    logic [8:0] u;
    u = {b, nack};
    for (int i = 8; i >= 0; i--) begin
      sda = u[i];
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
      #Q;
    end
  endtask
endmodule
`default_nettype wire

// [verification/tb_i2c_bus_trigger_decoder.sv]
// Self-checking bench: APB setup, I2C traffic, trigger and record checks
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_bus_trigger_decoder;
  logic pclk;
  logic presetn;
  i2c_mon_pkg::apb_req_t apb_req;
  i2c_mon_pkg::apb_rsp_t apb_rsp;
  wire logic scl;
  wire logic sda;
  logic trig_out;
  logic frame_done;
  i2c_mon_pkg::frame_rec_t frame_rec;
  i2c_mon_pkg::frame_rec_t rec_seen;
  int err_total = 0;
  int n_checks = 0;
  int trig_cnt = 0;
  int done_cnt = 0;
  // Rows: ctrl, trigger count, record count
  logic [31:0] mtab [8][3] = '{'{32'h001, 32'h1, 32'h1}, '{32'h101, 32'h1, 32'h1},
    '{32'h201, 32'h0, 32'h1}, '{32'h301, 32'h1, 32'h1}, '{32'h401, 32'h1, 32'h1},
    '{32'h421, 32'h0, 32'h1}, '{32'h701, 32'h0, 32'h1}, '{32'h000, 32'h0, 32'h0}};
  // Rows: kind, target, ctrl, value, care, offset/length, trigger count
  logic [31:0] atab [10][7] = '{
    '{32'h0, 32'h050, 32'h501, 32'h0, 32'h0, 32'h10000, 32'h1},
    '{32'h0, 32'h051, 32'h501, 32'h0, 32'h0, 32'h10000, 32'h0},
    '{32'h0, 32'h050, 32'h521, 32'h0, 32'h0, 32'h10000, 32'h0},
    '{32'h0, 32'h050, 32'h511, 32'hC3, 32'hFF, 32'h10001, 32'h1},
    '{32'h0, 32'h050, 32'h511, 32'hC33C, 32'hFFFF, 32'h20000, 32'h1},
    '{32'h0, 32'h050, 32'h511, 32'h3C, 32'hFF, 32'h10001, 32'h0},
    '{32'h0, 32'h050, 32'h511, 32'hC1, 32'h01, 32'h10001, 32'h1},
    '{32'h0, 32'h050, 32'h519, 32'hC1, 32'h01, 32'h10001, 32'h0},
    '{32'h0, 32'h050, 32'h511, 32'hC33C, 32'hFFFFFF, 32'h30000, 32'h0},
    '{32'h2, 32'h3FF, 32'h501, 32'h0, 32'h0, 32'h10000, 32'h1}};

  i2c_bus_trigger_decoder i_i2c_bus_trigger_decoder (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .scl_in(scl),
    .sda_in(sda),
    .trig_out(trig_out),
    .frame_done(frame_done),
    .frame_rec(frame_rec)
  );

  i2c_bus_model i_i2c_bus_model (
    .scl(scl),
    .sda(sda)
  );

  // ----------------------------------------
  // Clock, tallies, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Pulses last one cycle, so every edge is looked at
  always @(posedge pclk) begin
    if (trig_out === 1'b1) trig_cnt <= trig_cnt + 1;
    if (frame_done === 1'b1) begin
      done_cnt <= done_cnt + 1;
      rec_seen <= frame_rec;
    end
  end

  // Well above the expected run length, under the cycle budget
  initial begin
    #300000;
    err_total++;
    test_done();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Setup, access until pready, then one idle edge before the next
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready", 32'h1, 32'h0);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, exp & m, q & m);
    check("pslverr", {31'h0, exp_err}, {31'h0, e});
  endtask

  // Kinds: 0 write frame, 1 with restart, 2 ten-bit, 3 empty, 4 capture ends mid-frame
  task automatic frame(input logic [31:0] kind, input logic [31:0] et, input logic [31:0] ed);
    int t0;
    int d0;
    t0 = trig_cnt;
    d0 = done_cnt;
    i_i2c_bus_model.start();
    case (kind)
      0: begin
        i_i2c_bus_model.put_byte(8'hA0, 1'b0);
        i_i2c_bus_model.put_byte(8'h3C, 1'b0);
        i_i2c_bus_model.put_byte(8'hC3, 1'b1);
      end
      1: begin
        i_i2c_bus_model.put_byte(8'hA0, 1'b0);
        i_i2c_bus_model.start();
        i_i2c_bus_model.put_byte(8'hA1, 1'b0);
        i_i2c_bus_model.put_byte(8'h5A, 1'b1);
      end
      2: begin
        i_i2c_bus_model.put_byte(8'hF6, 1'b0);
        i_i2c_bus_model.put_byte(8'hFF, 1'b0);
        i_i2c_bus_model.put_byte(8'h12, 1'b0);
      end
      4: begin
        i_i2c_bus_model.put_byte(8'hA0, 1'b0);
        // Realign to the clock before the bus master speaks
        @(posedge pclk);
        wr(i2c_mon_pkg::OFS_CTRL, 32'h700);
      end
      default: ;
    endcase
    i_i2c_bus_model.stop();
    repeat (20) @(posedge pclk);
    check("trigger count", et, 32'(trig_cnt - t0));
    check("record count", ed, 32'(done_cnt - d0));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    rd_chk("ctrl", i2c_mon_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0, 1'b0);
    rd_chk("pcfg", i2c_mon_pkg::OFS_PCFG, 32'hFFFFFFFF, 32'h10000, 1'b0);
    rd_chk("unmapped", 8'h24, 32'hFFFFFFFF, 32'h0, 1'b1);
    wr(i2c_mon_pkg::OFS_PCFG, 32'h0);
    rd_chk("pcfg", i2c_mon_pkg::OFS_PCFG, 32'h30000, 32'h10000, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(i2c_mon_pkg::OFS_CTRL, mtab[i][0]);
      frame(32'h0, mtab[i][1], mtab[i][2]);
    end
    check("state", 32'(i2c_mon_pkg::FS_OK), 32'(rec_seen.state));
    check("addr", 32'h050, 32'(rec_seen.addr));
    check("count", 32'h2, 32'(rec_seen.count));
    check("data", 32'h3CC3, 32'(rec_seen.data[15:0]));
    rd_chk("rinfo", i2c_mon_pkg::OFS_RINFO, 32'hFFFF3FF7, 32'h20500, 1'b0);
    rd_chk("status", i2c_mon_pkg::OFS_STAT, 32'hB, 32'hB, 1'b0);
    wr(i2c_mon_pkg::OFS_STAT, 32'hB);
    rd_chk("status", i2c_mon_pkg::OFS_STAT, 32'hB, 32'h0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      wr(i2c_mon_pkg::OFS_TADDR, atab[i][1]);
      wr(i2c_mon_pkg::OFS_PVAL, atab[i][3]);
      wr(i2c_mon_pkg::OFS_PCARE, atab[i][4]);
      wr(i2c_mon_pkg::OFS_PCFG, atab[i][5]);
      wr(i2c_mon_pkg::OFS_CTRL, atab[i][2]);
      frame(atab[i][0], atab[i][6], 32'h1);
    end
    check("addr", 32'h3FF, 32'(rec_seen.addr));
    check("count", 32'h1, 32'(rec_seen.count));
    check("early frame sign", 32'h1, 32'(rec_seen.start_time[31]));
    wr(i2c_mon_pkg::OFS_CTRL, 32'h005);
    frame(32'h0, 32'h1, 32'h1);
    check("addr", 32'h0A0, 32'(rec_seen.addr));
    check("start time", 32'h0, rec_seen.start_time);
    rd_chk("rtime", i2c_mon_pkg::OFS_RTIME, 32'hFFFFFFFF, 32'h0, 1'b0);
    wr(i2c_mon_pkg::OFS_CTRL, 32'h201);
    frame(32'h1, 32'h1, 32'h2);
    check("dir", 32'h1, 32'(rec_seen.dir));
    check("count", 32'h1, 32'(rec_seen.count));
    wr(i2c_mon_pkg::OFS_CTRL, 32'h701);
    frame(32'h3, 32'h0, 32'h1);
    check("state", 32'(i2c_mon_pkg::FS_DATA), 32'(rec_seen.state));
    wr(i2c_mon_pkg::OFS_CTRL, 32'h701);
    frame(32'h4, 32'h0, 32'h1);
    check("state", 32'(i2c_mon_pkg::FS_CUT), 32'(rec_seen.state));
    test_done();
  end
endmodule
`default_nettype wire
